// ==== shared/strobe_port_defines.vh ====
// Constants for the four-bit strobe port and the open-drain select register.
// Assumes a byte-wide register port with 8-bit addresses on the system clock.
//
// What this block does
// - Pins zero and one are output-only and, as ports, drive their latch bit whatever the direction bit.
// - Reset sets every latch bit to one and clears the direction and function registers.
// - After reset pins zero and one drive high and pins two and three are inputs with pull-ups on.
// - With pin zero in read-strobe use and its latch bit zero, the read strobe appears on every read, internal too.
// - With pin zero in read-strobe use and its latch bit one, the read strobe appears only on external accesses.
// - Pin one in function use gives the write strobe only on external accesses, ignoring direction and latch.
// - Direction picks in or out on pins two and three; function use gives two high write at 1, three read/write at 0.
// - A bidirectional pin in input mode has its pull-up switched by its latch bit, zero off and one on.
// - The direction and function registers are write-only and are written whole, never by read-modify-write.
// - Seven output pins on other ports each select push-pull (0) or open-drain (1) drive by their own bit.
// - Reset clears the open-drain select register so every affected pin starts push-pull.

`ifndef STROBE_PORT_DEFINES_VH
`define STROBE_PORT_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_OPEN_DRAIN_SELECT   8'h3f
`define ADDR_PORT_DATA_LATCH     8'h7d
`define ADDR_PORT_DIRECTION      8'h7e
`define ADDR_PORT_FUNCTION       8'h7f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PORT_LATCH           4'hf
`define RST_PORT_DIRECTION       2'h0
`define RST_PORT_FUNCTION        4'h0
`define RST_OPEN_DRAIN           7'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PIN_READ_STROBE          0
`define PIN_WRITE_STROBE         1
`define PIN_HIGH_WRITE           2
`define PIN_DIRECTION_SIGNAL     3
`define LATCH_MSB                3
`define DIRECTION_LSB            2
`define DIRECTION_MSB            3
`define OPEN_DRAIN_MSB           6

// ----------------------------------------------------------------
// Widths and fill values
// ----------------------------------------------------------------
`define OPEN_DRAIN_PINS          7
`define READ_ZERO                8'h00

`endif

// ==== hw/level_sync.v ====
// Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes the reset input is already synchronous to clock on its release.

`timescale 1ns/1ns

module level_sync #(
    parameter WIDTH = 2
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    // First stage feeds only the second stage to keep metastability contained
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= {WIDTH{1'b1}};
            stage2_reg <= {WIDTH{1'b1}};
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule // level_sync

// ==== hw/strobe_port.v ====
// Four-bit bus strobe port with a separate open-drain select register.
// Assumes bus-cycle strobes come from CPU logic on the same clock and pad levels come from outside it.
//
// The strobed register port was left to the implementer.

`timescale 1ns/1ns

`include "strobe_port_defines.vh"

module strobe_port (
    input  wire                         clock,
    input  wire                         rst_n,
    // Register port
    input  wire [7:0]                   reg_addr,
    input  wire [7:0]                   reg_wdata,
    input  wire                         reg_write,
    input  wire                         reg_read,
    output reg  [7:0]                   reg_rdata,
    // Bus cycle from the CPU, same clock
    input  wire                         bus_rd_n,
    input  wire                         bus_wr_n,
    input  wire                         bus_hwr_n,
    input  wire                         bus_rw,
    input  wire                         bus_external,
    // Output-only pins
    output reg                          read_strobe_pin,
    output reg                          write_strobe_pin,
    // Bidirectional pin two
    input  wire                         high_write_pin_in,
    output reg                          high_write_pin_out,
    output reg                          high_write_pin_oe_n,
    output reg                          high_write_pull_up,
    // Bidirectional pin three
    input  wire                         direction_signal_pin_in,
    output reg                          direction_signal_pin_out,
    output reg                          direction_signal_pin_oe_n,
    output reg                          direction_signal_pull_up,
    // Output pins of other ports with selectable drive
    input  wire [`OPEN_DRAIN_PINS-1:0]  od_port_data,
    input  wire [`OPEN_DRAIN_PINS-1:0]  od_port_drive,
    output reg  [`OPEN_DRAIN_PINS-1:0]  od_pin_out,
    output reg  [`OPEN_DRAIN_PINS-1:0]  od_pin_oe_n,
    // Current drive selection, for the pad ring
    output wire [`OPEN_DRAIN_PINS-1:0]  open_drain_select
);

    // ----------------------------------------------------------------
    // Bidirectional pin modes
    // ----------------------------------------------------------------
    localparam [1:0] MODE_INPUT    = 2'b00;
    localparam [1:0] MODE_OUTPUT   = 2'b01;
    localparam [1:0] MODE_FUNCTION = 2'b10;
    localparam [1:0] MODE_RESERVED = 2'b11;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    reg                           rst_meta_reg;
    reg                           rst_sync_reg;
    wire                          rst_sync_n;

    // Assertion is immediate, release waits two edges
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_sync_n = rst_sync_reg;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [`LATCH_MSB:0]                      strobe_port_latch_reg;
    reg  [`DIRECTION_MSB:`DIRECTION_LSB]     strobe_port_direction_reg;
    reg  [`LATCH_MSB:0]                      strobe_port_function_reg;
    reg  [`OPEN_DRAIN_MSB:0]                 open_drain_select_reg;
    reg  [7:0]                               reg_rdata_next;

    wire                                     read_strobe_select;
    wire [1:0]                               pad_sync;

    assign read_strobe_select = strobe_port_function_reg[`PIN_READ_STROBE];
    assign open_drain_select  = open_drain_select_reg;

    // Data latch: writes store all four bits, even for pins read back as pad levels
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            strobe_port_latch_reg <= `RST_PORT_LATCH;
        end else if (reg_write && reg_addr == `ADDR_PORT_DATA_LATCH) begin
            strobe_port_latch_reg <= reg_wdata[`LATCH_MSB:0];
        end
    end

    // Only pins two and three have a direction bit
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            strobe_port_direction_reg <= `RST_PORT_DIRECTION;
        end else if (reg_write && reg_addr == `ADDR_PORT_DIRECTION) begin
            strobe_port_direction_reg <= reg_wdata[`DIRECTION_MSB:`DIRECTION_LSB];
        end
    end

    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            strobe_port_function_reg <= `RST_PORT_FUNCTION;
        end else if (reg_write && reg_addr == `ADDR_PORT_FUNCTION) begin
            strobe_port_function_reg <= reg_wdata[`LATCH_MSB:0];
        end
    end

    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            open_drain_select_reg <= `RST_OPEN_DRAIN;
        end else if (reg_write && reg_addr == `ADDR_OPEN_DRAIN_SELECT) begin
            open_drain_select_reg <= reg_wdata[`OPEN_DRAIN_MSB:0];
        end
    end

    // ----------------------------------------------------------------
    // Pad input synchronisers
    // ----------------------------------------------------------------
    level_sync #(
        .WIDTH    (2)
    ) u_pad_sync (
        .clock    (clock),
        .rst_n    (rst_sync_n),
        .async_in ({direction_signal_pin_in, high_write_pin_in}),
        .sync_out (pad_sync)
    );

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    // Direction and function read as zero; software must keep its own copy
    always @* begin
        reg_rdata_next = `READ_ZERO;
        case (reg_addr)
            `ADDR_PORT_DATA_LATCH: begin
                reg_rdata_next[`PIN_READ_STROBE]      = strobe_port_latch_reg[`PIN_READ_STROBE];
                reg_rdata_next[`PIN_WRITE_STROBE]     = strobe_port_latch_reg[`PIN_WRITE_STROBE];
                reg_rdata_next[`PIN_HIGH_WRITE]       = pad_sync[0];
                reg_rdata_next[`PIN_DIRECTION_SIGNAL] = pad_sync[1];
            end
            `ADDR_OPEN_DRAIN_SELECT: begin
                reg_rdata_next[`OPEN_DRAIN_MSB:0] = open_drain_select_reg;
            end
            `ADDR_PORT_DIRECTION, `ADDR_PORT_FUNCTION: begin
                reg_rdata_next = `READ_ZERO;
            end
            default: begin
                reg_rdata_next = `READ_ZERO;
            end
        endcase
    end

    // Read data stands for one cycle only, zero otherwise
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= `READ_ZERO;
        end else if (reg_read) begin
            reg_rdata <= reg_rdata_next;
        end else begin
            reg_rdata <= `READ_ZERO;
        end
    end

    // ----------------------------------------------------------------
    // Mode decode for the bidirectional pins
    // ----------------------------------------------------------------
    // Function use is legal only on one direction setting per pin
    function [1:0] pin_mode;
        input func_bit;
        input dir_bit;
        input func_dir;
        begin
            if (!func_bit) begin
                pin_mode = dir_bit ? MODE_OUTPUT : MODE_INPUT;
            end else if (dir_bit == func_dir) begin
                pin_mode = MODE_FUNCTION;
            end else begin
                pin_mode = MODE_RESERVED;
            end
        end
    endfunction

    wire [1:0] high_write_mode;
    wire [1:0] direction_signal_mode;

    assign high_write_mode       = pin_mode(strobe_port_function_reg[`PIN_HIGH_WRITE],
                                            strobe_port_direction_reg[`PIN_HIGH_WRITE], 1'b1);
    assign direction_signal_mode = pin_mode(strobe_port_function_reg[`PIN_DIRECTION_SIGNAL],
                                            strobe_port_direction_reg[`PIN_DIRECTION_SIGNAL], 1'b0);

    // ----------------------------------------------------------------
    // Output-only pins
    // ----------------------------------------------------------------
    reg read_strobe_next;
    reg write_strobe_next;

    always @* begin
        if (!read_strobe_select) begin
            read_strobe_next = strobe_port_latch_reg[`PIN_READ_STROBE];
        end else if (!strobe_port_latch_reg[`PIN_READ_STROBE]) begin
            read_strobe_next = bus_rd_n;
        end else begin
            read_strobe_next = bus_rd_n | ~bus_external;
        end
        if (!strobe_port_function_reg[`PIN_WRITE_STROBE]) begin
            write_strobe_next = strobe_port_latch_reg[`PIN_WRITE_STROBE];
        end else begin
            write_strobe_next = bus_wr_n | ~bus_external;
        end
    end

    // ----------------------------------------------------------------
    // Bidirectional pins
    // ----------------------------------------------------------------
    reg high_write_out_next;
    reg high_write_oe_n_next;
    reg high_write_pull_next;
    reg direction_signal_out_next;
    reg direction_signal_oe_n_next;
    reg direction_signal_pull_next;

    // Reserved modes float the pin with no pull-up, the safest choice
    always @* begin
        high_write_out_next  = strobe_port_latch_reg[`PIN_HIGH_WRITE];
        high_write_oe_n_next = 1'b1;
        high_write_pull_next = 1'b0;
        case (high_write_mode)
            MODE_INPUT: begin
                high_write_pull_next = strobe_port_latch_reg[`PIN_HIGH_WRITE];
            end
            MODE_OUTPUT: begin
                high_write_oe_n_next = 1'b0;
            end
            MODE_FUNCTION: begin
                high_write_out_next  = bus_hwr_n | ~bus_external;
                high_write_oe_n_next = 1'b0;
            end
            default: begin
                high_write_oe_n_next = 1'b1;
            end
        endcase
    end

    always @* begin
        direction_signal_out_next  = strobe_port_latch_reg[`PIN_DIRECTION_SIGNAL];
        direction_signal_oe_n_next = 1'b1;
        direction_signal_pull_next = 1'b0;
        case (direction_signal_mode)
            MODE_INPUT: begin
                direction_signal_pull_next = strobe_port_latch_reg[`PIN_DIRECTION_SIGNAL];
            end
            MODE_OUTPUT: begin
                direction_signal_oe_n_next = 1'b0;
            end
            MODE_FUNCTION: begin
                direction_signal_out_next  = bus_rw;
                direction_signal_oe_n_next = 1'b0;
            end
            default: begin
                direction_signal_oe_n_next = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Drive selection for the other ports
    // ----------------------------------------------------------------
    reg [`OPEN_DRAIN_PINS-1:0] od_out_next;
    reg [`OPEN_DRAIN_PINS-1:0] od_oe_n_next;

    genvar g;
    generate
        for (g = 0; g < `OPEN_DRAIN_PINS; g = g + 1) begin : g_drive
            // Open drain only ever pulls low; a one releases the wire
            always @* begin
                if (open_drain_select_reg[g]) begin
                    od_out_next[g]  = 1'b0;
                    od_oe_n_next[g] = ~(od_port_drive[g] & ~od_port_data[g]);
                end else begin
                    od_out_next[g]  = od_port_data[g];
                    od_oe_n_next[g] = ~od_port_drive[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Pin output flops
    // ----------------------------------------------------------------
    // One cycle of latency on every pin, traded for glitch-free pads
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            read_strobe_pin           <= 1'b1;
            write_strobe_pin          <= 1'b1;
            high_write_pin_out        <= 1'b1;
            high_write_pin_oe_n       <= 1'b1;
            high_write_pull_up        <= 1'b1;
            direction_signal_pin_out  <= 1'b1;
            direction_signal_pin_oe_n <= 1'b1;
            direction_signal_pull_up  <= 1'b1;
            od_pin_out                <= {`OPEN_DRAIN_PINS{1'b0}};
            od_pin_oe_n               <= {`OPEN_DRAIN_PINS{1'b1}};
        end else begin
            read_strobe_pin           <= read_strobe_next;
            write_strobe_pin          <= write_strobe_next;
            high_write_pin_out        <= high_write_out_next;
            high_write_pin_oe_n       <= high_write_oe_n_next;
            high_write_pull_up        <= high_write_pull_next;
            direction_signal_pin_out  <= direction_signal_out_next;
            direction_signal_pin_oe_n <= direction_signal_oe_n_next;
            direction_signal_pull_up  <= direction_signal_pull_next;
            od_pin_out                <= od_out_next;
            od_pin_oe_n               <= od_oe_n_next;
        end
    end

endmodule // strobe_port

// ==== bench/strobe_port_props.sv ====
// Checker for the strobe port: pin functions, read data and drive selection.
// Assumes it is bound to strobe_port and that no write comes before the reset release.
`timescale 1ns/1ns
module strobe_port_props (
    input wire       clock,
    input wire       rst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_write,
    input wire       reg_read,
    input wire [7:0] reg_rdata,
    input wire       bus_rd_n,
    input wire       bus_wr_n,
    input wire       bus_hwr_n,
    input wire       bus_rw,
    input wire       bus_external,
    input wire       read_strobe_pin,
    input wire       write_strobe_pin,
    input wire       high_write_pin_out,
    input wire       high_write_pin_oe_n,
    input wire       high_write_pull_up,
    input wire       direction_signal_pin_out,
    input wire       direction_signal_pin_oe_n,
    input wire [6:0] od_port_data,
    input wire [6:0] od_port_drive,
    input wire [6:0] od_pin_out,
    input wire [6:0] od_pin_oe_n
);
    // ------------------------------------------------------------
    // Shadow registers
    // ------------------------------------------------------------
    // Checks wait three edges: two for the reset release, one for the pin flops
    reg  [1:0] cnt_reg;
    reg  [3:0] fn_reg;
    reg  [3:0] lat_reg;
    reg  [3:0] dir_reg;
    reg  [6:0] ods_reg;
    wire       ok = (cnt_reg == 2'h3);
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 2'h0;
            fn_reg  <= 4'h0;
            lat_reg <= 4'hf;
            dir_reg <= 4'h0;
            ods_reg <= 7'h00;
        end else begin
            if (!ok) cnt_reg <= cnt_reg + 2'h1;
            if (reg_write && reg_addr == 8'h7f) fn_reg <= reg_wdata[3:0];
            if (reg_write && reg_addr == 8'h7d) lat_reg <= reg_wdata[3:0];
            if (reg_write && reg_addr == 8'h7e) dir_reg <= reg_wdata[3:0];
            if (reg_write && reg_addr == 8'h3f) ods_reg <= reg_wdata[6:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    AST_PIN0_PORT: assert property (ok && !$past(fn_reg[0]) |-> read_strobe_pin == $past(lat_reg[0]))
        else $error("pin 0 does not follow its latch");
    AST_PIN1_PORT: assert property (ok && !$past(fn_reg[1]) |-> write_strobe_pin == $past(lat_reg[1]))
        else $error("pin 1 does not follow its latch");
    AST_RD_ALWAYS: assert property (ok && $past(fn_reg[0] && !lat_reg[0])
        |-> read_strobe_pin == $past(bus_rd_n)) else $error("read strobe not given on every read");
    AST_RD_EXT: assert property (ok && $past(fn_reg[0] && lat_reg[0])
        |-> read_strobe_pin == $past(bus_rd_n | !bus_external)) else $error("read strobe outside external");
    AST_WR_EXT: assert property (ok && $past(fn_reg[1])
        |-> write_strobe_pin == $past(bus_wr_n | !bus_external)) else $error("write strobe wrong");
    AST_HWR: assert property (ok && $past(fn_reg[2] && dir_reg[2]) |-> !high_write_pin_oe_n
        && high_write_pin_out == $past(bus_hwr_n | !bus_external)) else $error("high write strobe wrong");
    AST_RW: assert property (ok && $past(fn_reg[3] && !dir_reg[3]) |-> !direction_signal_pin_oe_n
        && direction_signal_pin_out == $past(bus_rw)) else $error("direction signal wrong");
    AST_PULL: assert property (ok && $past(!fn_reg[2] && !dir_reg[2]) |-> high_write_pin_oe_n
        && high_write_pull_up == $past(lat_reg[2])) else $error("pull-up does not follow latch");
    AST_WO_READ: assert property (reg_read && (reg_addr == 8'h7e || reg_addr == 8'h7f) |=> reg_rdata == 8'h00)
        else $error("write-only register read back nonzero");
    AST_OD_READ: assert property (reg_read && reg_addr == 8'h3f |=> reg_rdata == {1'b0, ods_reg})
        else $error("drive select read wrong");
    AST_OD_DRIVE: assert property (ok |-> od_pin_out == $past(od_port_data & ~ods_reg)
        && od_pin_oe_n == $past(~(od_port_drive & ~(ods_reg & od_port_data))))
        else $error("drive mode output wrong");
    COV_RD_ALWAYS: cover property (ok && $past(fn_reg[0] && !lat_reg[0]) && !read_strobe_pin);
    COV_HWR: cover property (ok && $past(fn_reg[2] && dir_reg[2]) && !high_write_pin_out);
    COV_OD: cover property (ok && |ods_reg && |(~od_pin_oe_n));
endmodule // strobe_port_props

bind strobe_port strobe_port_props i_strobe_port_props (.*);

// ==== bench/pad_model.sv ====
// Pad seen from the board side: external driver, on-chip pull-up or a floating line.
// Assumes the design's own drive wins over the board.
`timescale 1ns/1ns
module pad_model (
    input  wire clock,
    input  wire pin_out,
    input  wire pin_oe_n,
    input  wire pull_up,
    input  wire ext_en,
    input  wire ext_val,
    output wire pad
);
    // A floating pad toggles so a stale level never matches
    reg churn_reg = 1'b0;
    always @(posedge clock) churn_reg <= ~churn_reg;
    assign pad = !pin_oe_n ? pin_out : ext_en ? ext_val : pull_up ? 1'b1 : churn_reg;
endmodule // pad_model

// ==== bench/tb_top.sv ====
// Self-checking bench for the strobe port.
// Assumes the checker is bound in and the pads are modelled by pad_model.
`timescale 1ns/1ns
module tb_top;
    logic clock, rst_n, reg_write, reg_read;
    logic [7:0] reg_addr, reg_wdata;
    wire  [7:0] reg_rdata;
    logic bus_rd_n, bus_wr_n, bus_hwr_n, bus_rw, bus_external;
    wire  read_strobe_pin, write_strobe_pin, high_write_pin_in, direction_signal_pin_in;
    wire  high_write_pin_out, high_write_pin_oe_n, high_write_pull_up;
    wire  direction_signal_pin_out, direction_signal_pin_oe_n, direction_signal_pull_up;
    logic [6:0] od_port_data, od_port_drive;
    wire  [6:0] od_pin_out, od_pin_oe_n, open_drain_select;
    logic [1:0] ext_en, ext_val;
    int error_cnt = 0;
    int comparisons = 0;

    strobe_port i_strobe_port (.*);
    pad_model i_pad_model_2 (.clock(clock), .pin_out(high_write_pin_out), .pin_oe_n(high_write_pin_oe_n),
        .pull_up(high_write_pull_up), .ext_en(ext_en[0]), .ext_val(ext_val[0]), .pad(high_write_pin_in));
    pad_model i_pad_model_3 (.clock(clock), .pin_out(direction_signal_pin_out),
        .pin_oe_n(direction_signal_pin_oe_n), .pull_up(direction_signal_pull_up), .ext_en(ext_en[1]),
        .ext_val(ext_val[1]), .pad(direction_signal_pin_in));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ------------------------------------------------------------
    // Bus cycles and compares
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk8(reg_rdata, exp);
    endtask
    // Order is read, write, high write, direction, external
    task automatic bus(input logic [4:0] v);
        @(posedge clock);
        {bus_rd_n, bus_wr_n, bus_hwr_n, bus_rw, bus_external} <= v;
        @(posedge clock);
        #1;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h0, got}, {7'h0, exp});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        #1;
        chk1(read_strobe_pin & write_strobe_pin, 1'b1);
        chk1(high_write_pin_oe_n & direction_signal_pin_oe_n, 1'b1);
        chk1(high_write_pull_up & direction_signal_pull_up, 1'b1);
        chk8({1'b0, open_drain_select}, 8'h00);
        rd(8'h7d, 8'h0f);
        rd(8'h3f, 8'h00);
        rd(8'h7e, 8'h00);
        rd(8'h7f, 8'h00);
        rd(8'h10, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_port;
        // Whole writes only, no read-modify-write
        wr(8'h7e, 8'h03);
        wr(8'h7d, 8'h00);
        ext_val <= 2'b10;
        ext_en <= 2'b11;
        bus(5'h1f);
        chk1(read_strobe_pin | write_strobe_pin, 1'b0);
        chk1(high_write_pull_up | direction_signal_pull_up, 1'b0);
        repeat (3) @(posedge clock);
        rd(8'h7d, 8'h08);
        wr(8'h7e, 8'h0c);
        wr(8'h7d, 8'h04);
        bus(5'h1f);
        chk1(high_write_pin_out & ~high_write_pin_oe_n, 1'b1);
        chk1(direction_signal_pin_out | direction_signal_pin_oe_n, 1'b0);
        chk1(read_strobe_pin | write_strobe_pin, 1'b0);
        repeat (3) @(posedge clock);
        rd(8'h7d, 8'h04);
        ext_en <= 2'b00;
        wr(8'h7e, 8'h00);
        wr(8'h7d, 8'h0f);
        bus(5'h1f);
        chk1(high_write_pull_up & direction_signal_pull_up, 1'b1);
        $display("test port done");
    endtask
    task automatic t_strobe;
        wr(8'h7d, 8'h0e);
        wr(8'h7f, 8'h01);
        bus(5'b01100);
        chk1(read_strobe_pin, 1'b0);
        bus(5'b11100);
        chk1(read_strobe_pin, 1'b1);
        wr(8'h7d, 8'h0f);
        bus(5'b01100);
        chk1(read_strobe_pin, 1'b1);
        bus(5'b01101);
        chk1(read_strobe_pin, 1'b0);
        wr(8'h7e, 8'h04);
        wr(8'h7f, 8'h0f);
        bus(5'b10000);
        chk1(write_strobe_pin & high_write_pin_out, 1'b1);
        chk1(direction_signal_pin_out, 1'b0);
        bus(5'b10011);
        chk1(write_strobe_pin | high_write_pin_out, 1'b0);
        chk1(direction_signal_pin_out & ~direction_signal_pin_oe_n, 1'b1);
        wr(8'h7e, 8'h08);
        bus(5'h1f);
        chk1(high_write_pin_oe_n & direction_signal_pin_oe_n, 1'b1);
        chk1(high_write_pull_up | direction_signal_pull_up, 1'b0);
        wr(8'h7f, 8'h00);
        wr(8'h7e, 8'h00);
        $display("test strobe done");
    endtask
    task automatic t_od;
        @(posedge clock);
        od_port_data <= 7'h55;
        od_port_drive <= 7'h3c;
        wr(8'h3f, 8'hff);
        bus(5'h1f);
        chk8({1'b0, od_pin_out}, 8'h00);
        chk8({1'b0, od_pin_oe_n}, 8'h57);
        rd(8'h3f, 8'h7f);
        wr(8'h3f, 8'h0f);
        wr(8'h3e, 8'h00);
        bus(5'h1f);
        chk8({1'b0, od_pin_out}, 8'h50);
        chk8({1'b0, od_pin_oe_n}, 8'h47);
        rd(8'h3f, 8'h0f);
        wr(8'h3f, 8'h00);
        bus(5'h1f);
        chk8({1'b0, od_pin_out}, 8'h55);
        chk8({1'b0, od_pin_oe_n}, 8'h43);
        $display("test drive select done");
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        {reg_write, reg_read, reg_addr, reg_wdata} = 18'h0;
        {bus_rd_n, bus_wr_n, bus_hwr_n, bus_rw, bus_external} = 5'h1e;
        {od_port_data, od_port_drive} = 14'h0;
        {ext_en, ext_val} = 4'h0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_reset;
        t_port;
        t_strobe;
        t_od;
        finish_test;
    end
    initial begin
        #100000;
        $display("watchdog expired");
        error_cnt++;
        finish_test;
    end
endmodule // tb_top
